// *** design/sacs_sequencer.sv ***
// Conversion sequencer: control byte capture, track/hold timing, result readout
`timescale 1ns/1ns
`include "sacs_consts.svh"

//
// What this block does
// - Tracking begins on every write strobe rising edge except one that ends external acquisition.
// - External acquisition holds on the next write rising edge that has acquisition select cleared.
// - Internal acquisition holds on fourth conversion-clock falling edge after write.
// - With internal oscillator, internal hold comes 240 to 320 ns after write (three to four 80 ns periods).
// - Single-ended ties negative side to common; pseudo-differential uses paired channel.
// - Conversion lasts exactly 13 conversion-clock cycles.
// - Write during conversion aborts it and starts fresh acquisition.
// - Acquisition select cleared opens internally timed acquisition then converts.
// - Set then cleared acquisition select: convert on second write rising edge.
// - Completion flag goes low when conversion finishes and data is ready.
// - Completion flag returns high on first read or new control write.
// - Power bits decode off, standby, internal osc, external clock; off keeps clock.
// - Bit 5 selects internal or external acquisition timing.
// - Bit 4 selects pseudo-differential or single-ended input.
// - Bit 3 selects bipolar or unipolar conversion.
// - Three lowest bits choose channel or channel pair.
// - Control byte captured from data lines on write; same lines drive reads.
// - High byte select chooses low eight bits or top two, sign filled if bipolar, zero filled if unipolar.
// - Chip select high ignores strobes and clock and floats data and flag.
// - Power-up in external clock mode, flag high; host waits ten microseconds.
module sacs_sequencer
  import sacs_pkg::*;
#(
  parameter int POR_CYC = `SACS_POR_CYC
) (
  // System
  input  wire logic                      clk_sys,
  input  wire logic                      reset,
  // Host port
  input  wire logic                      chipSelect_n,
  input  wire logic                      write_n,
  input  wire logic                      read_n,
  input  wire logic                      highByteSelect,
  input  wire logic [7:0]                dataIn,
  output logic      [7:0]                dataOut,
  output logic                           dataOe,
  output logic                           convDone_n,
  output logic                           convDoneOe,
  // Conversion clock pin
  input  wire logic                      extClk,
  // Converter core
  input  wire logic                      compareBit,
  output logic                           sampleEnable,
  output logic      [2:0]                posChannel,
  output logic      [2:0]                negChannel,
  output logic                           negToCommon,
  output logic                           bipolarMode,
  output logic      [`SACS_RESULT_W-1:0] dacCode,
  output logic                           standby,
  output logic                           powerDown,
  output logic                           resetBusy
);
  // ----------------------------------------------------------------
  // Strobe qualification
  // ----------------------------------------------------------------
  logic       wrPrev_q;
  logic       rdPrev_q;
  logic       wrRise;
  logic       rdFall;
  logic       selected;
  logic [15:0] porCnt_q;

  assign selected = !chipSelect_n;
  assign wrRise   = selected && write_n && !wrPrev_q;
  assign rdFall   = selected && !read_n && rdPrev_q;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wrPrev_q <= 1'b1;
      rdPrev_q <= 1'b1;
    end else begin
      wrPrev_q <= write_n | chipSelect_n;
      rdPrev_q <= read_n | chipSelect_n;
    end
  end

  // Writes during the power-on settling window are not refused; host must wait
  always_ff @(posedge clk_sys) begin
    if (reset) porCnt_q <= 16'h0000;
    else if (porCnt_q != 16'(POR_CYC)) porCnt_q <= porCnt_q + 16'h0001;
  end

  // ----------------------------------------------------------------
  // Control byte
  // ----------------------------------------------------------------
  sacs_ctrl_t ctrl_q;
  sacs_ctrl_t newCtrl;
  logic       intClock_q;

  assign newCtrl = sacs_ctrl_t'(dataIn);

  always_ff @(posedge clk_sys) begin
    if (reset) ctrl_q <= sacs_ctrl_t'(8'hC0);
    else if (wrRise) ctrl_q <= newCtrl;
  end

  // Power-down codes keep the last clock choice
  always_ff @(posedge clk_sys) begin
    if (reset) intClock_q <= 1'b0;
    else if (wrRise && newCtrl.powerMode == SACS_PM_INOSC) intClock_q <= 1'b1;
    else if (wrRise && newCtrl.powerMode == SACS_PM_EXCLK) intClock_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Conversion clock
  // ----------------------------------------------------------------
  logic convRise;
  logic convFall;

  sacs_conv_clock u_clock (
    .clk_sys     (clk_sys),
    .reset       (reset),
    .useInternal (intClock_q),
    .extClk      (extClk & selected),
    .convRise    (convRise),
    .convFall    (convFall)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  sacs_state_t state_q;
  logic [3:0]  cycCnt_q;
  logic [`SACS_RESULT_W-1:0] sar_q;
  logic [`SACS_RESULT_W-1:0] result_q;
  logic [`SACS_RESULT_W-1:0] trial;
  logic        bitDone;
  logic        convEnd;

  // Bit under trial walks from MSB down one per conversion clock
  function automatic logic [`SACS_RESULT_W-1:0] trialMask(input logic [3:0] idx);
    trialMask = `SACS_RESULT_W'(1) << (`SACS_RESULT_W - 1 - int'(idx));
  endfunction : trialMask

  assign bitDone = (cycCnt_q >= 4'h1) && (cycCnt_q <= 4'(`SACS_RESULT_W));
  assign trial   = trialMask(cycCnt_q - 4'h1);
  assign convEnd = (state_q == SACS_CONVERT) && convRise
                   && (cycCnt_q == 4'(`SACS_CONV_CYCLES - 1));

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_q  <= SACS_IDLE;
      cycCnt_q <= 4'h0;
    end else if (wrRise) begin
      cycCnt_q <= 4'h0;
      if (newCtrl.acquisitionSelect)
        state_q <= SACS_ACQ_EXT;
      else if (state_q == SACS_ACQ_EXT)
        state_q <= SACS_CONVERT;
      else
        state_q <= SACS_ACQ_INT;
    end else begin
      case (state_q)
        SACS_ACQ_INT: begin
          if (convFall) begin
            if (cycCnt_q == 4'(`SACS_HOLD_FALL - 1)) begin
              state_q  <= SACS_CONVERT;
              cycCnt_q <= 4'h0;
            end else begin
              cycCnt_q <= cycCnt_q + 4'h1;
            end
          end
        end
        SACS_CONVERT: begin
          if (convEnd) state_q <= SACS_IDLE;
          else if (convRise) cycCnt_q <= cycCnt_q + 4'h1;
        end
        SACS_ACQ_EXT: state_q <= SACS_ACQ_EXT;
        SACS_IDLE:    state_q <= SACS_IDLE;
        default:      state_q <= SACS_IDLE;
      endcase
    end
  end

  // Successive approximation register
  always_ff @(posedge clk_sys) begin
    if (reset) sar_q <= '0;
    else if (state_q != SACS_CONVERT) sar_q <= `SACS_RESULT_W'(1) << (`SACS_RESULT_W - 1);
    else if (convRise && bitDone) begin
      sar_q <= (compareBit ? sar_q : (sar_q & ~trial))
               | (trial >> 1);
    end
  end

  // Result held until next completion
  always_ff @(posedge clk_sys) begin
    if (reset) result_q <= '0;
    else if (convEnd) result_q <= sar_q;
  end

  // ----------------------------------------------------------------
  // Completion flag and host readout
  // ----------------------------------------------------------------
  logic       done_q;
  logic [7:0] readByte;
  sacs_route_t route;

  // Completion outranks a same-cycle read
  always_ff @(posedge clk_sys) begin
    if (reset) done_q <= 1'b0;
    else if (convEnd) done_q <= 1'b1;
    else if (wrRise || rdFall) done_q <= 1'b0;
  end

  sacs_output_mux u_mux (
    .result         (result_q),
    .highByteSelect (highByteSelect),
    .bipolar        (!ctrl_q.polaritySelect),
    .ctrl           (ctrl_q),
    .readByte       (readByte),
    .route          (route)
  );

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      dataOut    <= 8'h00;
      dataOe     <= 1'b0;
      convDone_n <= 1'b1;
      convDoneOe <= 1'b0;
    end else begin
      dataOut    <= readByte;
      dataOe     <= selected && !read_n;
      convDone_n <= !(convEnd || (done_q && !wrRise && !rdFall));
      convDoneOe <= selected;
    end
  end

  // ----------------------------------------------------------------
  // Converter core controls
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sampleEnable <= 1'b0;
      posChannel   <= 3'h0;
      negChannel   <= 3'h0;
      negToCommon  <= 1'b0;
      bipolarMode  <= 1'b0;
      dacCode      <= '0;
      standby      <= 1'b0;
      powerDown    <= 1'b0;
      resetBusy    <= 1'b1;
    end else begin
      sampleEnable <= (state_q == SACS_ACQ_INT) || (state_q == SACS_ACQ_EXT);
      posChannel   <= route.posChannel;
      negChannel   <= route.negChannel;
      negToCommon  <= route.negToCommon;
      bipolarMode  <= !ctrl_q.polaritySelect;
      dacCode      <= sar_q;
      standby      <= (state_q == SACS_IDLE) && ctrl_q.powerMode == SACS_PM_STBY;
      powerDown    <= (state_q == SACS_IDLE) && ctrl_q.powerMode == SACS_PM_OFF;
      resetBusy    <= porCnt_q != 16'(POR_CYC);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_extArm;
    wrRise && newCtrl.acquisitionSelect;
  endsequence

  a_track_on_write: assert property (@(posedge clk_sys) disable iff (reset)
    wrRise |=> ##1 sampleEnable || state_q == SACS_CONVERT)
    else $error("no tracking after write");

  a_ext_hold_edge: assert property (@(posedge clk_sys) disable iff (reset)
    state_q == SACS_ACQ_EXT && wrRise && !newCtrl.acquisitionSelect
    |=> state_q == SACS_CONVERT)
    else $error("external hold missed");

  a_ext_stays_acq: assert property (@(posedge clk_sys) disable iff (reset)
    s_extArm ##1 (!wrRise) [*4] |-> state_q == SACS_ACQ_EXT)
    else $error("external acquisition ended early");

  a_int_hold_fall: assert property (@(posedge clk_sys) disable iff (reset)
    state_q == SACS_ACQ_INT && !wrRise && convFall && cycCnt_q == 4'h3
    |=> state_q == SACS_CONVERT && cycCnt_q == 4'h0)
    else $error("internal hold not on fourth fall");

  a_conv_length: assert property (@(posedge clk_sys) disable iff (reset)
    convEnd && !wrRise |-> cycCnt_q == 4'hC ##1 state_q == SACS_IDLE)
    else $error("conversion length wrong");

  a_write_aborts: assert property (@(posedge clk_sys) disable iff (reset)
    state_q == SACS_CONVERT && wrRise && !newCtrl.acquisitionSelect
    |=> state_q == SACS_ACQ_INT)
    else $error("write did not abort conversion");

  a_flag_on_done: assert property (@(posedge clk_sys) disable iff (reset)
    convEnd |=> !convDone_n && result_q == $past(sar_q))
    else $error("flag or result missing at completion");

  a_flag_clears: assert property (@(posedge clk_sys) disable iff (reset)
    (rdFall || wrRise) && !convEnd |=> convDone_n)
    else $error("flag not cleared");

  a_high_byte: assert property (@(posedge clk_sys) disable iff (reset)
    highByteSelect && ctrl_q.polaritySelect |=> dataOut[7:2] == 6'h00)
    else $error("unipolar high byte not zero filled");

  a_float_deselect: assert property (@(posedge clk_sys) disable iff (reset)
    chipSelect_n |=> !dataOe && !convDoneOe)
    else $error("outputs driven while deselected");

  // ----------------------------------------------------------------
  // Readout, routing and clock-mode checks
  // ----------------------------------------------------------------
  // Read byte is registered, so both readout checks compare with last cycle's result
  a_low_byte: assert property (@(posedge clk_sys) disable iff (reset)
    !highByteSelect |=> dataOut == $past(result_q[7:0]))
    else $error("low result byte wrong");

  a_sign_fill: assert property (@(posedge clk_sys) disable iff (reset)
    highByteSelect && !ctrl_q.polaritySelect
    |=> dataOut == {{6{$past(result_q[9])}}, $past(result_q[9:8])})
    else $error("bipolar high byte not sign filled");

  a_read_drives: assert property (@(posedge clk_sys) disable iff (reset)
    selected && !read_n |=> dataOe && convDoneOe)
    else $error("data not driven during read");

  a_route_common: assert property (@(posedge clk_sys) disable iff (reset)
    1'b1 |=> negToCommon == $past(ctrl_q.inputConfigSelect))
    else $error("negative side routing wrong");

  a_clock_choice: assert property (@(posedge clk_sys) disable iff (reset)
    wrRise && newCtrl.powerMode == SACS_PM_INOSC |=> intClock_q)
    else $error("internal clock not chosen");

  // Power-down codes must not disturb the clock source of the next wake-up
  a_clock_kept: assert property (@(posedge clk_sys) disable iff (reset)
    wrRise && (newCtrl.powerMode == SACS_PM_OFF || newCtrl.powerMode == SACS_PM_STBY)
    |=> $stable(intClock_q))
    else $error("power-down code changed clock mode");
endmodule : sacs_sequencer

// *** design/sacs_consts.svh ***
// Constants of the conversion sequencer: fields, counts, timings
`ifndef SACS_CONSTS_SVH
`define SACS_CONSTS_SVH
`define SACS_PM_HI_BIT      7
`define SACS_PM_LO_BIT      6
`define SACS_ACQ_BIT        5
`define SACS_CFG_BIT        4
`define SACS_POL_BIT        3
`define SACS_CH_MSB         2
`define SACS_CH_LSB         0
`define SACS_ACQ_EDGES      3
`define SACS_HOLD_FALL      4
`define SACS_CONV_CYCLES    13
`define SACS_CLK_NS         10
`define SACS_INT_ACQ_NS     1000
`define SACS_INT_ACQ_CYC    ((`SACS_INT_ACQ_NS) / (`SACS_CLK_NS))
`define SACS_OSC_HALF_NS    40
`define SACS_OSC_HALF_CYC   (((`SACS_OSC_HALF_NS) + (`SACS_CLK_NS) - 1) / (`SACS_CLK_NS))
`define SACS_POR_NS         10000
`define SACS_POR_CYC        (((`SACS_POR_NS) + (`SACS_CLK_NS) - 1) / (`SACS_CLK_NS))
`define SACS_RESULT_W       10
`endif

// *** design/sacs_pkg.sv ***
// Types of the conversion sequencer
package sacs_pkg;
  typedef enum logic [1:0] {
    SACS_PM_OFF   = 2'h0,
    SACS_PM_STBY  = 2'h1,
    SACS_PM_INOSC = 2'h2,
    SACS_PM_EXCLK = 2'h3
  } sacs_pmode_t;

  typedef enum logic [2:0] {
    SACS_IDLE    = 3'h0,
    SACS_ACQ_INT = 3'h1,
    SACS_CONVERT = 3'h3,
    SACS_ACQ_EXT = 3'h5
  } sacs_state_t;

  typedef struct packed {
    sacs_pmode_t powerMode;
    logic        acquisitionSelect;
    logic        inputConfigSelect;
    logic        polaritySelect;
    logic [2:0]  channelSel;
  } sacs_ctrl_t;

  typedef struct packed {
    logic       negToCommon;
    logic [2:0] posChannel;
    logic [2:0] negChannel;
  } sacs_route_t;
endpackage : sacs_pkg

// *** design/sacs_conv_clock.sv ***
// Conversion clock source: edge pulses from internal oscillator or external pin
`timescale 1ns/1ns
`include "sacs_consts.svh"
module sacs_conv_clock
  import sacs_pkg::*;
#(
  parameter int HALF_CYC = `SACS_OSC_HALF_CYC
) (
  // System
  input  wire logic clk_sys,
  input  wire logic reset,
  // Source select and pin
  input  wire logic useInternal,
  input  wire logic extClk,
  // Edge pulses
  output logic      convRise,
  output logic      convFall
);
  logic [7:0] divCnt_q;
  logic       oscLevel_q;
  logic       extPrev_q;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      divCnt_q   <= 8'h00;
      oscLevel_q <= 1'b0;
    end else if (divCnt_q == 8'(HALF_CYC - 1)) begin
      divCnt_q   <= 8'h00;
      oscLevel_q <= ~oscLevel_q;
    end else begin
      divCnt_q <= divCnt_q + 8'h01;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) extPrev_q <= 1'b0;
    else extPrev_q <= extClk;
  end

  always_comb begin
    if (useInternal) begin
      convRise = (divCnt_q == 8'(HALF_CYC - 1)) && !oscLevel_q;
      convFall = (divCnt_q == 8'(HALF_CYC - 1)) && oscLevel_q;
    end else begin
      convRise = extClk && !extPrev_q;
      convFall = !extClk && extPrev_q;
    end
  end
endmodule : sacs_conv_clock

// *** design/sacs_output_mux.sv ***
// Result byte selection and input routing decode
`timescale 1ns/1ns
`include "sacs_consts.svh"
module sacs_output_mux
  import sacs_pkg::*;
(
  // Result and mode
  input  wire logic [`SACS_RESULT_W-1:0] result,
  input  wire logic                      highByteSelect,
  input  wire logic                      bipolar,
  input  wire sacs_ctrl_t                ctrl,
  // Outputs
  output logic [7:0]                     readByte,
  output sacs_route_t                    route
);
  always_comb begin
    if (highByteSelect)
      readByte = {{6{bipolar & result[9]}}, result[9:8]};
    else
      readByte = result[7:0];
  end

  always_comb begin
    route.posChannel  = ctrl.channelSel;
    route.negToCommon = ctrl.inputConfigSelect;
    route.negChannel  = ctrl.inputConfigSelect ? 3'h0 : (ctrl.channelSel ^ 3'h1);
  end
endmodule : sacs_output_mux

// *** testbench/sacs_host_model.sv ***
// Host bus master, external conversion clock and comparator model
`timescale 1ns/1ns
module sacs_host_model
  import sacs_pkg::*;
(
  // System
  input  wire logic       clk_sys,
  // Host port
  output logic            chipSelect_n,
  output logic            write_n,
  output logic            read_n,
  output logic            highByteSelect,
  output logic [7:0]      dataIn,
  input  wire logic [7:0] dataOut,
  // Converter side
  output logic            extClk,
  output logic            compareBit,
  input  wire logic [9:0] dacCode,
  input  wire logic [9:0] target
);
  int extCnt = 0;
  initial begin
    chipSelect_n = 1'b0;
    write_n = 1'b1;
    read_n = 1'b1;
    highByteSelect = 1'b0;
    dataIn = 8'h00;
    extClk = 1'b0;
  end
  // Free-running conversion clock, period of ten system cycles
  always @(posedge clk_sys) begin
    extCnt <= (extCnt == 4) ? 0 : extCnt + 1;
    if (extCnt == 4) extClk <= ~extClk;
  end
  // Trial bit kept while the code does not overshoot the input
  assign compareBit = (dacCode <= target);
  // Control byte write; data lines scrambled once the hold is over
  task wr(input logic [7:0] b);
    @(posedge clk_sys);
    dataIn <= b;
    write_n <= 1'b0;
    @(posedge clk_sys);
    write_n <= 1'b1;
    @(posedge clk_sys);
    dataIn <= ~b;
  endtask : wr
  task rd(input logic h, output logic [7:0] v);
    @(posedge clk_sys);
    highByteSelect <= h;
    read_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    v = dataOut;
    read_n <= 1'b1;
    @(posedge clk_sys);
  endtask : rd
  task sel(input logic off);
    @(posedge clk_sys);
    chipSelect_n <= off;
  endtask : sel
endmodule : sacs_host_model

// *** testbench/sar_adc_conversion_sequencer_tb.sv ***
// Self-checking bench of the conversion sequencer
`timescale 1ns/1ns
module sar_adc_conversion_sequencer_tb
  import sacs_pkg::*;
;
  typedef struct packed {
    logic [7:0] ctrl;
    logic [9:0] tgt;
    logic [7:0] lo;
    logic [7:0] hi;
  } sacs_row_t;
  logic       clk_sys = 1'b0;
  logic       reset = 1'b1;
  logic       chipSelect_n, write_n, read_n, highByteSelect, extClk, compareBit;
  logic [7:0] dataIn, dataOut, v;
  logic       dataOe, convDone_n, convDoneOe, sampleEnable, negToCommon;
  logic       bipolarMode, standby, powerDown, resetBusy;
  logic [2:0] posChannel, negChannel;
  logic [9:0] dacCode;
  logic [9:0] target = 10'h000;
  logic       intOsc = 1'b0;
  int         fail_count = 0;
  int         total_checks = 0;
  int         n;
  // Ctrl byte, comparator input, low byte, high byte
  sacs_row_t  rows [8] = '{
    '{8'h98, 10'h3A5, 8'hA5, 8'h03}, '{8'hC9, 10'h2F0, 8'hF0, 8'h02},
    '{8'h92, 10'h381, 8'h81, 8'hFF}, '{8'hC3, 10'h17E, 8'h7E, 8'h01},
    '{8'h9C, 10'h000, 8'h00, 8'h00}, '{8'hD5, 10'h3FF, 8'hFF, 8'hFF},
    '{8'h86, 10'h200, 8'h00, 8'hFE}, '{8'hDF, 10'h155, 8'h55, 8'h01}};

  always #5 clk_sys = ~clk_sys;

  sacs_sequencer #(.POR_CYC(10)) uut (
    .clk_sys(clk_sys), .reset(reset), .chipSelect_n(chipSelect_n), .write_n(write_n),
    .read_n(read_n), .highByteSelect(highByteSelect), .dataIn(dataIn), .dataOut(dataOut),
    .dataOe(dataOe), .convDone_n(convDone_n), .convDoneOe(convDoneOe), .extClk(extClk),
    .compareBit(compareBit), .sampleEnable(sampleEnable), .posChannel(posChannel),
    .negChannel(negChannel), .negToCommon(negToCommon), .bipolarMode(bipolarMode),
    .dacCode(dacCode), .standby(standby), .powerDown(powerDown), .resetBusy(resetBusy));

  sacs_host_model host (
    .clk_sys(clk_sys), .chipSelect_n(chipSelect_n), .write_n(write_n), .read_n(read_n),
    .highByteSelect(highByteSelect), .dataIn(dataIn), .dataOut(dataOut), .extClk(extClk),
    .compareBit(compareBit), .dacCode(dacCode), .target(target));

  task tick();
    @(posedge clk_sys);
    #1;
  endtask : tick
  task chk(input string name, input logic [9:0] exp, input logic [9:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      fail_count++;
    end
  endtask : chk
  task rng(input string name, input int lo, input int hi, input int got);
    total_checks++;
    if (got < lo || got > hi) begin
      $display("wrong value %s expected %0d..%0d seen %0d", name, lo, hi, got);
      fail_count++;
    end
  endtask : rng
  // Bounded waits: a hang shows as an out-of-range count
  task wait_hold(output int c);
    c = 0;
    while (sampleEnable !== 1'b0 && c < 600) begin
      tick();
      c++;
    end
  endtask : wait_hold
  task wait_done(output int c);
    c = 0;
    while (convDone_n !== 1'b0 && c < 600) begin
      tick();
      c++;
    end
  endtask : wait_done
  task conclude();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude

  task run_row(input sacs_row_t r);
    int per;
    if (r.ctrl[7]) intOsc = !r.ctrl[6];
    per = intOsc ? 8 : 10;
    target = r.tgt;
    host.wr(r.ctrl);
    repeat (3) tick();
    chk("track", 1'b1, sampleEnable);
    chk("pos", r.ctrl[2:0], posChannel);
    chk("common", r.ctrl[4], negToCommon);
    if (!r.ctrl[4]) chk("neg", r.ctrl[2:0] ^ 3'h1, negChannel);
    chk("bipolar", !r.ctrl[3], bipolarMode);
    wait_hold(n);
    rng("hold", 3 * per - 6, 4 * per + 6, n);
    wait_done(n);
    rng("conv", 12 * per, 13 * per + 6, n);
    host.rd(1'b0, v);
    chk("low", r.lo, v);
    chk("flag", 1'b1, convDone_n);
    host.rd(1'b1, v);
    chk("high", r.hi, v);
    host.rd(1'b0, v);
    chk("held", r.lo, v);
  endtask : run_row

  initial begin
    #200000;
    fail_count++;
    conclude();
  end

  initial begin
    repeat (5) tick();
    chk("busy", 1'b1, resetBusy);
    chk("flag", 1'b1, convDone_n);
    chk("sample", 1'b0, sampleEnable);
    chk("oe", 1'b0, dataOe);
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (5) tick();
    chk("busy", 1'b1, resetBusy);
    n = 0;
    while (resetBusy !== 1'b0 && n < 50) begin
      tick();
      n++;
    end
    chk("busy", 1'b0, resetBusy);
    chk("flagoe", 1'b1, convDoneOe);
    foreach (rows[i]) run_row(rows[i]);
    // Externally timed acquisition stays open until the second write
    target = 10'h2C3;
    host.wr(8'hB8);
    repeat (80) tick();
    chk("open", 1'b1, sampleEnable);
    chk("flag", 1'b1, convDone_n);
    host.wr(8'h98);
    repeat (3) tick();
    chk("hold", 1'b0, sampleEnable);
    wait_done(n);
    rng("conv", 11 * 8, 13 * 8 + 8, n);
    host.rd(1'b0, v);
    chk("low", 8'hC3, v);
    // Abort in mid-conversion
    target = 10'h0AA;
    host.wr(8'h98);
    repeat (60) tick();
    chk("conv", 1'b0, sampleEnable);
    target = 10'h311;
    host.wr(8'h98);
    repeat (3) tick();
    chk("retrack", 1'b1, sampleEnable);
    wait_done(n);
    rng("abort", 14 * 8, 18 * 8 + 12, n);
    host.wr(8'h98);
    repeat (3) tick();
    chk("flag", 1'b1, convDone_n);
    // Power-down codes
    host.wr(8'h00);
    n = 0;
    while (powerDown !== 1'b1 && n < 600) begin
      tick();
      n++;
    end
    chk("pdown", 1'b1, powerDown);
    host.wr(8'h40);
    n = 0;
    while (standby !== 1'b1 && n < 600) begin
      tick();
      n++;
    end
    chk("stby", 1'b1, standby);
    // Deselected: outputs float, write strobe ignored
    host.sel(1'b1);
    repeat (3) tick();
    chk("oe", 1'b0, dataOe);
    chk("flagoe", 1'b0, convDoneOe);
    host.wr(8'h98);
    repeat (5) tick();
    chk("sample", 1'b0, sampleEnable);
    host.sel(1'b0);
    tick();
    chk("flag", 1'b0, convDone_n);
    // Reset in mid-run: flag back high, clock source back to the pin
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (2) tick();
    chk("flag", 1'b1, convDone_n);
    chk("busy", 1'b1, resetBusy);
    chk("sample", 1'b0, sampleEnable);
    @(posedge clk_sys);
    reset <= 1'b0;
    intOsc = 1'b0;
    n = 0;
    while (resetBusy !== 1'b0 && n < 50) begin
      tick();
      n++;
    end
    chk("busy", 1'b0, resetBusy);
    run_row('{8'h18, 10'h0F3, 8'hF3, 8'h00});
    conclude();
  end
endmodule : sar_adc_conversion_sequencer_tb
